//--- rtl/smr_pkg.sv
/*
  Shared constants for the sensor result interface: channel counts, count
  and result widths, the scan rate and the clock rate that times it.
  Assumes a single 250 MHz system clock.
*/
package smr_pkg;
  localparam int CLK_HZ = 250_000_000;
  localparam int SCAN_RATE_HZ = 4000;
  localparam int SCAN_PERIOD_CYC = CLK_HZ / SCAN_RATE_HZ;
  localparam int NUM_CH = 22;
  localparam int CH_W = 5;
  localparam logic [CH_W-1:0] REF_CH = 5'h15;
  localparam logic [CH_W-1:0] LAST_CH = 5'h15;
  localparam int COUNT_W = 12;
  localparam int RESULT_W = 16;
  localparam int NUM_VR = 2;
  localparam int NUM_HALL = 2;
  localparam logic [RESULT_W-1:0] RESULT_RST = 16'h0000;
  localparam logic HALL_RST = 1'b1;
  typedef enum logic [1:0] {SMR_IDLE, SMR_REQ, SMR_DONE} smr_state_e;
endpackage : smr_pkg

//--- rtl/smr_result_if.sv
/*
  Result side of the sensor input module: scans 22 converter channels at a
  fixed rate, holds each count in a result register, pulses when a scan is
  complete, and conditions the reluctor and hall comparator levels.
  Assumes a converter front end that answers each channel request with one
  valid pulse, and comparator inputs synchronous to clk_i.
*/
`timescale 1ns/1ns
module smr_result_if
  import smr_pkg::*;
#(
  parameter int SCAN_PERIOD = SCAN_PERIOD_CYC
) (
  input wire logic clk_i,                                 // System clock, 250 MHz.
  input wire logic sys_rst_i,                             // Asynchronous reset, high.
  output logic conv_req_o,                                // Conversion request level.
  output logic [CH_W-1:0] conv_chan_o,                    // Channel to convert, 0 based.
  input wire logic conv_valid_i,                          // Conversion result strobe.
  input wire logic [COUNT_W-1:0] conv_data_i,             // Conversion count.
  output logic [NUM_CH*RESULT_W-1:0] result_o,            // Results, channel 0 lowest.
  output logic sweep_done_pulse_o,                        // One cycle per completed scan.
  input wire logic [NUM_VR-1:0] vr_neg_cross_i,           // Armed negative zero crossing.
  input wire logic [NUM_VR-1:0] vr_at_zero_i,             // Reluctor signal back at 0 V.
  output logic [NUM_VR-1:0] reluctor_edge_out_o,          // Reluctor speed outputs.
  input wire logic [NUM_HALL-1:0] hall_above_hi_i,        // Hall input above 2.0 V.
  input wire logic [NUM_HALL-1:0] hall_below_lo_i,        // Hall input below 1.0 V.
  output logic [NUM_HALL-1:0] hall_level_out_o            // Inverted hall levels.
);

  ////////////////////////////////////////////////////////////////////////////
  // Scan timer.

  logic [31:0] tick_cnt, next_tick_cnt;
  logic tick;

  // The timer runs free, so the scan rate does not depend on how long the
  // converter takes to answer; a tick that finds a scan still running is lost.
  assign tick = (tick_cnt == 32'(SCAN_PERIOD - 1));

  always_comb begin
    if (tick) begin
      next_tick_cnt = 32'h0000_0000;
    end else begin
      next_tick_cnt = tick_cnt + 32'h0000_0001;
    end
  end

  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      tick_cnt <= 32'h0000_0000;
    end else begin
      tick_cnt <= next_tick_cnt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Scan sequencer.

  smr_state_e state, next_state;
  logic [CH_W-1:0] chan, next_chan;
  logic req, next_req;
  logic done, next_done;
  logic store;

  // Converter answers are taken only while a scan waits on them.
  assign store = (state == SMR_REQ) && conv_valid_i;

  // The pulse is raised one state after the last result lands, so every
  // result register already shows the new scan when the host sees it.
  always_comb begin
    next_state = state;
    next_chan = chan;
    next_req = req;
    next_done = 1'b0;
    case (state)
      SMR_IDLE: begin
        if (tick) begin
          next_state = SMR_REQ;
          next_chan = '0;
          next_req = 1'b1;
        end
      end
      SMR_REQ: begin
        if (store) begin
          if (chan == LAST_CH) begin
            next_req = 1'b0;
            next_state = SMR_DONE;
          end else begin
            next_chan = chan + 5'h01;
          end
        end
      end
      SMR_DONE: begin
        next_done = 1'b1;
        next_state = SMR_IDLE;
      end
      default: begin
        next_state = SMR_IDLE;
        next_req = 1'b0;
      end
    endcase
  end

  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      state <= SMR_IDLE;
      chan <= '0;
      req <= 1'b0;
      done <= 1'b0;
    end else begin
      state <= next_state;
      chan <= next_chan;
      req <= next_req;
      done <= next_done;
    end
  end

  assign conv_req_o = req;
  assign conv_chan_o = chan;
  assign sweep_done_pulse_o = done;

  ////////////////////////////////////////////////////////////////////////////
  // Result registers, one per channel; the last one holds the reference.

  for (genvar g = 0; g < NUM_CH; g++) begin : g_result
    logic [RESULT_W-1:0] held, next_held;

    // The count is zero extended, so the result never reads as negative.
    always_comb begin
      if (store && (chan == CH_W'(g))) begin
        next_held = {{(RESULT_W - COUNT_W){1'b0}}, conv_data_i};
      end else begin
        next_held = held;
      end
    end

    always_ff @(posedge clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
        held <= RESULT_RST;
      end else begin
        held <= next_held;
      end
    end

    assign result_o[g*RESULT_W +: RESULT_W] = held;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Reluctor outputs, one per input.

  for (genvar g = 0; g < NUM_VR; g++) begin : g_vr
    logic level, next_level;

    // A fresh crossing wins over a return to zero seen in the same cycle.
    always_comb begin
      if (vr_neg_cross_i[g]) begin
        next_level = 1'b1;
      end else if (vr_at_zero_i[g]) begin
        next_level = 1'b0;
      end else begin
        next_level = level;
      end
    end

    always_ff @(posedge clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
        level <= 1'b0;
      end else begin
        level <= next_level;
      end
    end

    assign reluctor_edge_out_o[g] = level;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Hall outputs, one per input.

  for (genvar g = 0; g < NUM_HALL; g++) begin : g_hall
    logic level, next_level;
    logic hi_d, lo_d;

    // A threshold must be seen on two samples in a row, which filters
    // single-cycle glitches; the high threshold wins a tie.
    always_comb begin
      if (hall_above_hi_i[g] && hi_d) begin
        next_level = 1'b0;
      end else if (hall_below_lo_i[g] && lo_d) begin
        next_level = 1'b1;
      end else begin
        next_level = level;
      end
    end

    always_ff @(posedge clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
        level <= HALL_RST;
        hi_d <= 1'b0;
        lo_d <= 1'b0;
      end else begin
        level <= next_level;
        hi_d <= hall_above_hi_i[g];
        lo_d <= hall_below_lo_i[g];
      end
    end

    assign hall_level_out_o[g] = level;
  end

endmodule : smr_result_if

//--- tb/smr_asserts.sv
/* Port checker for smr_result_if; assumes it is bound onto that module. */
`timescale 1ns/1ns
module smr_asserts import smr_pkg::*; #(parameter int SCAN_PERIOD = SCAN_PERIOD_CYC) (
  input wire logic clk_i, // Clock.
  input wire logic sys_rst_i, // Reset.
  input wire logic conv_req_o, // Request.
  input wire logic [CH_W-1:0] conv_chan_o, // Channel.
  input wire logic conv_valid_i, // Strobe.
  input wire logic [COUNT_W-1:0] conv_data_i, // Count.
  input wire logic [NUM_CH*RESULT_W-1:0] result_o, // Results.
  input wire logic sweep_done_pulse_o, // Done.
  input wire logic [NUM_VR-1:0] vr_neg_cross_i, // Cross.
  input wire logic [NUM_VR-1:0] reluctor_edge_out_o, // Speed.
  input wire logic [NUM_HALL-1:0] hall_above_hi_i, // High.
  input wire logic [NUM_HALL-1:0] hall_below_lo_i, // Low.
  input wire logic [NUM_HALL-1:0] hall_level_out_o // Hall.
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (sys_rst_i);
  int cnt;
  logic seen;
  // Cycles since the last scan began, to time the next one.
  always_ff @(posedge clk_i or posedge sys_rst_i)
    if (sys_rst_i) {seen, cnt} <= '0;
    else if ($rose(conv_req_o)) {seen, cnt} <= {1'b1, 32'd1};
    else cnt <= cnt + 1;
  a_pulse_single: assert property (sweep_done_pulse_o |=> !sweep_done_pulse_o)
    else $error("pulse too long");
  a_pulse_after: assert property ($fell(conv_req_o) |-> ##1 sweep_done_pulse_o)
    else $error("pulse missing");
  a_scan_rate: assert property ($rose(conv_req_o) && seen |-> cnt == SCAN_PERIOD)
    else $error("scan spacing");
  a_ref_store: assert property (conv_req_o && conv_valid_i && conv_chan_o == REF_CH |=>
    result_o[REF_CH*RESULT_W +: RESULT_W] == $past(conv_data_i)) else $error("ref store");
  a_result_hold: assert property (!(conv_req_o && conv_valid_i) |=> $stable(result_o))
    else $error("result moved");
  a_vr_set: assert property (vr_neg_cross_i[0] |=> reluctor_edge_out_o[0])
    else $error("reluctor set");
  a_hall_low: assert property (hall_above_hi_i[0] [*2] |=> !hall_level_out_o[0])
    else $error("hall low");
  a_hall_high: assert property ((hall_below_lo_i[1] && !hall_above_hi_i[1]) [*2] |=>
    hall_level_out_o[1]) else $error("hall high");
endmodule : smr_asserts

//--- tb/smr_conv_model.sv
/* Converter model: answers each channel request after a random delay.
   Assumes the request and channel change only on rising clock edges. */
`timescale 1ns/1ns
module smr_conv_model import smr_pkg::*; (
  input wire logic clk_i, // Clock.
  input wire logic conv_req_i, // Request.
  input wire logic [CH_W-1:0] conv_chan_i, // Channel.
  output logic conv_valid_o = 1'b0, // Strobe.
  output logic [COUNT_W-1:0] conv_data_o // Count.
);
  logic [COUNT_W-1:0] cnt = '0;
  always @(negedge clk_i) begin
    conv_valid_o <= conv_req_i && $urandom_range(1);
    cnt <= (conv_chan_i == REF_CH) ? 12'h800 : 12'($urandom);
  end
  // Data off the strobe is inverted so stale values never look valid.
  assign conv_data_o = conv_valid_o ? cnt : ~cnt;
endmodule : smr_conv_model

//--- tb/tb_top.sv
/* Bench top: random sensor levels, converter model, queued checks; needs rtl first. */
`timescale 1ns/1ns
module tb_top;
  import smr_pkg::*;
  logic clk_i = 0, sys_rst_i = 1, conv_req_o, conv_valid_i, sweep_done_pulse_o;
  logic [CH_W-1:0] conv_chan_o;
  logic [COUNT_W-1:0] conv_data_i;
  logic [NUM_CH*RESULT_W-1:0] result_o;
  logic [1:0] vr_neg_cross_i = 0, vr_at_zero_i = 0, hall_above_hi_i = 0, hall_below_lo_i = 0;
  logic [1:0] reluctor_edge_out_o, hall_level_out_o, e_vr = 0, e_hl = 2'h3, p_ah, p_bl;
  logic [16:0] q_in[$];
  logic [3:0] q_out[$];
  int n_errors = 0, checked = 0, n_pulse = 0, cyc = 0, n_rise = 0, n_rise_exp = 0;
  logic prev_vr0 = 1'b0;
  smr_result_if #(.SCAN_PERIOD(200)) u_dut (.*);
  smr_conv_model u_conv (.clk_i(clk_i), .conv_req_i(conv_req_o), .conv_chan_i(conv_chan_o),
    .conv_valid_o(conv_valid_i), .conv_data_o(conv_data_i));
  initial forever #2 clk_i = ~clk_i;
  task automatic check(string what, logic [15:0] seen, logic [15:0] exp);
    checked++;
    if (seen !== exp) begin
      n_errors++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  task automatic end_sim();
    $display("checked %0d n_errors %0d", checked, n_errors);
    if (n_errors == 0 && checked > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : end_sim
  always @(negedge clk_i) #1 if (conv_valid_i) q_in.push_back({conv_chan_o, conv_data_i});
  always @(negedge clk_i) if (sweep_done_pulse_o === 1'b1) begin
    n_pulse++;
    foreach (q_in[k]) check("res", result_o[q_in[k][16:12]*16 +: 16], q_in[k][11:0]);
    check("ref", result_o[REF_CH*RESULT_W +: RESULT_W], 16'h0800);
    q_in.delete();
  end
  always @(posedge clk_i) begin
    cyc++;
    #1 if (q_out.size() > 0)
      check("lvl", {reluctor_edge_out_o, hall_level_out_o}, q_out.pop_front());
    n_rise += int'(reluctor_edge_out_o[0] === 1'b1 && prev_vr0 === 1'b0);
    prev_vr0 = reluctor_edge_out_o[0];
    if (cyc == 2000) begin
      n_errors++;
      end_sim();
    end
  end
  initial begin
    void'($urandom(70093));
    repeat (2) @(negedge clk_i);
    sys_rst_i = 0;
    {p_ah, p_bl} = '0;
    repeat (700) begin
      @(negedge clk_i);
      {vr_neg_cross_i, vr_at_zero_i, hall_above_hi_i} = 6'($urandom);
      hall_below_lo_i = 2'($urandom) & ~hall_above_hi_i;
      n_rise_exp += int'(vr_neg_cross_i[0] && !e_vr[0]);
      e_vr = vr_neg_cross_i | (e_vr & ~vr_at_zero_i);
      e_hl = (e_hl & ~(hall_above_hi_i & p_ah)) | (hall_below_lo_i & p_bl);
      {p_ah, p_bl} = {hall_above_hi_i, hall_below_lo_i};
      q_out.push_back({e_vr, e_hl});
    end
    @(negedge clk_i);
    check("pulses", 16'(n_pulse), 16'h0003);
    check("rises", 16'(n_rise), 16'(n_rise_exp));
    $display("random level and scan test done");
    end_sim();
  end
endmodule : tb_top
bind smr_result_if smr_asserts #(.SCAN_PERIOD(SCAN_PERIOD)) u_chk (.*);
